// ===== uts_top.sv
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "uts_regs.svh"
// What this block does
// RULE1: a buffer write after a status read is moved to the shifter and sent.
// RULE2: frame is start bit, eight data bits, optional parity, one or two stops.
// RULE3: when sending starts the buffer-empty flag sets and a transmit event fires.
// RULE4: transmit pin stays high while disabled and idle, or until the first byte is written.
// RULE5: a buffer write without a prior status read is ignored; no send starts.
// RULE6: after the stop bits, only data goes to the receive buffer; full flag, event.
// RULE7: a frame arriving while the buffer is full sets overrun and is discarded.
// RULE8: clearing receive enable takes effect once the current frame is over.
// RULE9: parity mismatch on a received frame sets the parity fault flag.
// RULE10: a zero sampled in any stop bit sets the framing flag.
// RULE11: receive flags clear on a receive buffer read after a status read; overrun only if that status read saw it set.
// RULE12: no reception is started while the overrun flag is set.
// RULE13: overrun set after the status read survives the following buffer read.
// RULE14: loading the receive buffer sets the receive-full flag.
// RULE15: buffer-empty flag clears on a buffer write after a status read.
// RULE16: transmit-done sets at frame end with empty buffer, clears at next start.
// RULE17: receiver hunts a low level, votes samples at ticks seven, eight and nine.
// RULE18: software disables both directions before changing the baud selection.
// RULE19: data go least significant bit first; one parity sense for both directions.
module uts_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    input wire logic ext_tick,
    output logic txd,
    output logic irq
);
    import uts_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [8:0] ctrl;
    logic [1:0] ist;
    logic [1:0] imask;
    logic armed;
    logic oerr_seen;
    logic tx_full;
    logic tx_done_flag;
    logic [7:0] tx_data_buffer;
    logic [7:0] rx_data_buffer;
    logic rx_full;
    logic overrun;
    logic parity_fault_flag;
    logic framing_flag;
    uts_tx_state_t tx_st;
    uts_rx_state_t rx_st;
    logic [11:0] tx_sh;
    logic [3:0] tx_idx;
    logic [3:0] tx_rt;
    logic [3:0] rx_idx;
    logic [3:0] rx_rt;
    logic [1:0] rx_smp;
    logic [7:0] rx_sh;
    logic rx_par;
    logic rx_stop_bad;
    logic [9:0] div_cnt;
    logic rxd_s;
    logic ext_s;
    logic ext_d;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    uts_sync #(.RST_VAL(1'b1)) u_rxd_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din(rxd),
        .dout(rxd_s)
    );

    uts_sync #(.RST_VAL(1'b0)) u_ext_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din(ext_tick),
        .dout(ext_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // control fields
    wire tx_enable = ctrl[`UTS_C_TXEN];
    wire rx_enable = ctrl[`UTS_C_RXEN];
    wire tx_stop_len = ctrl[`UTS_C_TSTB];
    wire even_sel = ctrl[`UTS_C_EVEN];
    wire parity_on = ctrl[`UTS_C_PAR];
    wire rx_stop_len = ctrl[`UTS_C_RSTB];
    wire [2:0] baud_select = ctrl[`UTS_C_BAUD_HI:`UTS_C_BAUD_LO];

    // apb decode; no wait states, so pready is constant high
    wire setup_rd = psel & ~penable & ~pwrite;
    wire acc = psel & penable;
    wire hit_ctrl = paddr == `UTS_CTRL_OFS;
    wire hit_stat = paddr == `UTS_STAT_OFS;
    wire hit_rxb = paddr == `UTS_RXB_OFS;
    wire hit_txb = paddr == `UTS_TXB_OFS;
    wire hit_ist = paddr == `UTS_IST_OFS;
    wire hit_imsk = paddr == `UTS_IMSK_OFS;
    wire mapped = hit_ctrl | hit_stat | hit_rxb | hit_txb | hit_ist | hit_imsk;
    wire wr = acc & pwrite & mapped;
    wire rd = acc & ~pwrite & mapped;
    wire rd_stat = rd & hit_stat;
    wire rd_rxb = rd & hit_rxb;
    wire wr_txb = wr & hit_txb;
    wire clr_rx = rd_rxb & armed; // see RULE11
    wire tx_load = wr_txb & armed; // see RULE5
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    // read mux, sampled in the setup cycle so prdata comes from a flop
    wire [7:0] stat_val = {parity_fault_flag, framing_flag, overrun, rx_full,
                           tx_done_flag, ~tx_full, 2'b00};
    wire [31:0] rd_mux = hit_ctrl ? {23'h000000, ctrl} :
                         hit_stat ? {24'h000000, stat_val} :
                         hit_rxb ? {24'h000000, rx_data_buffer} :
                         hit_ist ? {30'h00000000, ist} :
                         hit_imsk ? {30'h00000000, imask} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // baud tick: sixteen ticks per bit; a baud change mid-frame corrupts
    // that frame, which is why both directions must be idle first (see RULE18)
    wire [9:0] div_len = (baud_select == `UTS_BAUD_ALT) ? `UTS_ALT_DIV :
                         (`UTS_BASE_DIV << baud_select);
    wire use_ext = baud_select == `UTS_BAUD_EXT;
    wire div_wrap = div_cnt == (div_len - 10'h001);
    wire rt_tick = use_ext ? (ext_s & ~ext_d) : div_wrap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 10'h000;
            ext_d <= 1'b0;
        end else begin
            div_cnt <= (div_wrap | use_ext) ? 10'h000 : div_cnt + 10'h001;
            ext_d <= ext_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter decode
    wire tx_par = ^tx_data_buffer ^ ~even_sel; // see RULE19
    wire [3:0] tx_last = `UTS_PAR_IDX + {3'h0, parity_on} + {3'h0, tx_stop_len};
    wire tx_start = (tx_st == TX_IDLE) & tx_enable & tx_full; // see RULE1
    wire tx_bit_end = (tx_st == TX_SHIFT) & rt_tick & (tx_rt == `UTS_RT_LAST);
    wire tx_end = tx_bit_end & (tx_idx == tx_last);

    // transmit shifter; frame end always completes even if disabled meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st <= TX_IDLE;
            tx_sh <= 12'hFFF;
            tx_idx <= 4'h0;
            tx_rt <= 4'h0;
        end else if (tx_start) begin
            tx_st <= TX_SHIFT;
            tx_sh <= {2'b11, parity_on ? tx_par : 1'b1, tx_data_buffer, 1'b0}; // see RULE2
            tx_idx <= 4'h0;
            tx_rt <= 4'h0;
        end else if (tx_st == TX_SHIFT && rt_tick) begin
            tx_rt <= tx_rt + 4'h1;
            if (tx_bit_end) begin
                tx_sh <= {1'b1, tx_sh[11:1]}; // see RULE19
                tx_idx <= tx_idx + 4'h1;
                if (tx_end) begin
                    tx_st <= TX_IDLE;
                end
            end
        end
    end

    // pin is a flop; idle level high until a loaded byte starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd <= 1'b1;
        end else begin
            txd <= (tx_st == TX_SHIFT) ? tx_sh[0] : 1'b1; // see RULE4
        end
    end

    // transmit buffer and flags; a write in the start cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_full <= 1'b0;
            tx_done_flag <= 1'b1;
            tx_data_buffer <= 8'h00;
        end else begin
            tx_full <= tx_load | (tx_full & ~tx_start); // see RULE3 see RULE15
            if (tx_load) begin
                tx_data_buffer <= pwdata[7:0];
            end
            if (tx_start) begin
                tx_done_flag <= 1'b0; // see RULE16
            end else if (tx_end & ~tx_full) begin
                tx_done_flag <= 1'b1; // see RULE16
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver decode; majority of ticks seven, eight and nine
    wire rx_vote = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rxd_s) | (rx_smp[1] & rxd_s);
    wire [3:0] rx_last = `UTS_PAR_IDX + {3'h0, parity_on} + {3'h0, rx_stop_len};
    wire rx_mid = (rx_st == RX_BITS) & rt_tick & (rx_rt == `UTS_SMP9);
    wire rx_false = rx_mid & (rx_idx == 4'h0) & rx_vote;
    wire rx_done = rx_mid & (rx_idx == rx_last);
    wire rx_is_stop = rx_idx >= (`UTS_PAR_IDX + {3'h0, parity_on});
    wire rx_go = (rx_st == RX_HUNT) & rt_tick & ~rxd_s & rx_enable & ~overrun;
    wire rx_stop_bad_fin = rx_stop_bad | ~rx_vote; // see RULE10
    wire rx_par_bad = parity_on & (rx_par != (^rx_sh ^ ~even_sel)); // see RULE9
    wire rx_load = rx_done & ~rx_full;

    // receive shifter; enable is checked only at a frame start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st <= RX_HUNT;
            rx_idx <= 4'h0;
            rx_rt <= 4'h0;
            rx_smp <= 2'b11;
            rx_sh <= 8'h00;
            rx_par <= 1'b0;
            rx_stop_bad <= 1'b0;
        end else if (rx_go) begin
            rx_st <= RX_BITS; // see RULE8 see RULE12 see RULE17
            rx_idx <= 4'h0;
            rx_rt <= 4'h1;
            rx_stop_bad <= 1'b0;
        end else if (rx_st == RX_BITS && rt_tick) begin
            rx_rt <= rx_rt + 4'h1;
            if (rx_rt == `UTS_SMP7) begin
                rx_smp[0] <= rxd_s; // see RULE17
            end
            if (rx_rt == `UTS_SMP8) begin
                rx_smp[1] <= rxd_s;
            end
            if (rx_rt == `UTS_RT_LAST) begin
                rx_idx <= rx_idx + 4'h1;
            end
            if (rx_mid) begin
                if (rx_false | rx_done) begin
                    rx_st <= RX_HUNT;
                end
                if (rx_idx >= 4'h1 && rx_idx <= 4'h8) begin
                    rx_sh <= {rx_vote, rx_sh[7:1]}; // see RULE19
                end
                if (rx_idx == `UTS_PAR_IDX && parity_on) begin
                    rx_par <= rx_vote;
                end
                if (rx_is_stop && !rx_vote) begin
                    rx_stop_bad <= 1'b1;
                end
            end
        end
    end

    // receive buffer and flags; a new event wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_buffer <= 8'h00;
            rx_full <= 1'b0;
            overrun <= 1'b0;
            parity_fault_flag <= 1'b0;
            framing_flag <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_data_buffer <= rx_sh; // see RULE6 see RULE7
            end
            rx_full <= rx_load | (rx_full & ~clr_rx); // see RULE14 see RULE11
            overrun <= (rx_done & rx_full) | (overrun & ~(clr_rx & oerr_seen)); // see RULE13
            parity_fault_flag <= (rx_load & rx_par_bad) | (parity_fault_flag & ~clr_rx);
            framing_flag <= (rx_load & rx_stop_bad_fin) | (framing_flag & ~clr_rx);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers, access arming and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `UTS_CTRL_RST;
            imask <= 2'b00;
            armed <= 1'b0;
            oerr_seen <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            if (wr & hit_ctrl) begin
                ctrl <= pwdata[8:0];
            end
            if (wr & hit_imsk) begin
                imask <= pwdata[1:0];
            end
            // only an overrun seen by the status read may be cleared
            if (rd_stat) begin
                armed <= 1'b1;
                oerr_seen <= overrun;
            end else if (rd_rxb | wr_txb) begin
                armed <= 1'b0;
            end
            if (setup_rd) begin
                prdata <= rd_mux;
            end
        end
    end

    // sticky events, write one to clear, set wins
    wire [1:0] ev = {rx_load, tx_start};
    wire [1:0] ist_clr = (wr & hit_ist) ? pwdata[1:0] : 2'b00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist <= 2'b00;
        end else begin
            ist <= ev | (ist & ~ist_clr); // see RULE3 see RULE6
        end
    end

    assign irq = |(ist & imask);

    ////////////////////////////////////////////////////////////////////////
    // helper: a buffer write landing in the start cycle refills the buffer
    logic tx_load_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_load_d <= 1'b0;
        end else begin
            tx_load_d <= tx_load;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence tx_begin_s;
        tx_start ##1 (tx_st == TX_SHIFT);
    endsequence

    sequence start_low_s;
        ##1 !txd;
    endsequence

    tx_idle_high_a: assert property (!tx_enable && tx_st == TX_IDLE |=> txd) // see RULE4
        else $error("transmit pin not high while disabled");
    tx_start_flag_a: assert property (tx_begin_s |-> tx_full == tx_load_d // see RULE3
        && !tx_done_flag && ist[`UTS_I_TX])
        else $error("start did not set empty flag and event");
    tx_start_bit_a: assert property (tx_begin_s |-> start_low_s) // see RULE2
        else $error("start bit not low");
    tx_no_arm_a: assert property (wr_txb && !armed && !tx_full |=> !tx_full) // see RULE5
        else $error("unarmed write loaded the buffer");
    rx_load_a: assert property (rx_load |=> rx_full && ist[`UTS_I_RX]) // see RULE14
        else $error("load did not set full flag");
    rx_overrun_a: assert property (rx_done && rx_full |=> overrun && $stable(rx_data_buffer)) // see RULE7
        else $error("overrun did not keep buffer");
    rx_block_a: assert property (overrun && rx_st == RX_HUNT |=> rx_st == RX_HUNT) // see RULE12
        else $error("reception started during overrun");
    rx_clear_a: assert property (clr_rx && !rx_done |=> !rx_full && !framing_flag // see RULE11
        && !parity_fault_flag)
        else $error("flags not cleared by armed read");
    ovr_survive_a: assert property (clr_rx && overrun && !oerr_seen |=> overrun) // see RULE13
        else $error("late overrun lost");
    tx_end_flag_a: assert property (tx_end && !tx_full && !tx_load |=> tx_done_flag [*2]) // see RULE16
        else $error("done flag not set at frame end");
endmodule : uts_top

// ===== uts_regs.svh
`ifndef UTS_REGS_SVH
`define UTS_REGS_SVH
// register byte offsets
`define UTS_CTRL_OFS 8'h00
`define UTS_STAT_OFS 8'h04
`define UTS_RXB_OFS 8'h08
`define UTS_TXB_OFS 8'h0C
`define UTS_IST_OFS 8'h10
`define UTS_IMSK_OFS 8'h14
// control field positions
`define UTS_C_TXEN 0
`define UTS_C_RXEN 1
`define UTS_C_TSTB 2
`define UTS_C_EVEN 3
`define UTS_C_PAR 4
`define UTS_C_BAUD_LO 5
`define UTS_C_BAUD_HI 7
`define UTS_C_RSTB 8
`define UTS_CTRL_RST 9'h000
// interrupt status bit positions
`define UTS_I_TX 0
`define UTS_I_RX 1
// baud generation and bit timing
`define UTS_BASE_DIV 10'h00D
`define UTS_ALT_DIV 10'h060
`define UTS_BAUD_EXT 3'h6
`define UTS_BAUD_ALT 3'h7
`define UTS_RT_LAST 4'hF
`define UTS_SMP7 4'h7
`define UTS_SMP8 4'h8
`define UTS_SMP9 4'h9
`define UTS_PAR_IDX 4'h9
`endif

// ===== uts_pkg.sv
package uts_pkg;
    typedef enum logic {TX_IDLE, TX_SHIFT} uts_tx_state_t;
    typedef enum logic {RX_HUNT, RX_BITS} uts_rx_state_t;
endpackage : uts_pkg

// ===== uts_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for a level from outside the pclk domain
module uts_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta;

    // meta is read by dout only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : uts_sync

// ===== uts_remote.sv
`timescale 1ns/1ns
// far-end serial partner: decodes what the block sends, sends frames back
module uts_remote #(
    parameter int BIT_CLKS = 208
) (
    input wire logic pclk,
    input wire logic txd,
    output logic rxd
);
    logic [10:0] got;
    int frames;
    ////////////////////////////////////////////////////////////////////////////////
    // a released line rests at its pull-up level
    initial begin
        rxd = 1'b1;
    end
    // decoder: centre of the start bit, then one sample per bit, parity and stops too
    always begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            repeat (BIT_CLKS) @(posedge pclk);
            got[i] = txd;
        end
        frames++;
    end
    // one bit on the line, changed just after an edge
    task automatic put(input logic b);
        rxd <= b;
        repeat (BIT_CLKS) @(posedge pclk);
    endtask : put
    // one frame; a bad parity or a low stop only when a test asks for it
    task automatic send(input logic [7:0] d, input logic par, input logic even,
        input logic two, input logic bad_par, input logic bad_stop);
        @(posedge pclk);
        put(1'b0);
        for (int i = 0; i < 8; i++) begin
            put(d[i]);
        end
        if (par) begin
            put((even ? ^d : ~^d) ^ bad_par);
        end
        put(~bad_stop);
        if (two) begin
            put(1'b1);
        end
        rxd <= 1'b1;
    endtask : send
endmodule : uts_remote

// ===== uart_tx_rx_status_tb.sv
`timescale 1ns/1ns
`include "uts_regs.svh"
// bench: register traffic over the bus, frames through the remote model
module uart_tx_rx_status_tb;
    localparam logic [7:0] ct_a = `UTS_CTRL_OFS;
    localparam logic [7:0] st_a = `UTS_STAT_OFS;
    localparam logic [7:0] rx_a = `UTS_RXB_OFS;
    localparam logic [7:0] tx_a = `UTS_TXB_OFS;
    localparam logic [7:0] is_a = `UTS_IST_OFS;
    localparam logic [7:0] im_a = `UTS_IMSK_OFS;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic ext_tick;
    logic txd;
    logic irq;
    logic err_seen;
    logic [31:0] rdv;
    logic [7:0] d;
    logic par;
    logic two;
    int fail_count;
    int tests_run;
    int low_cnt;
    int low_snap;
    ////////////////////////////////////////////////////////////////////////////////
    uts_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .ext_tick(ext_tick),
        .txd(txd), .irq(irq));
    uts_remote rem_u (.pclk(pclk), .txd(txd), .rxd(rxd));
    // 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // external tick source, one rising edge every 13 clocks like the fastest divider
    initial begin
        ext_tick = 1'b0;
        forever begin
            repeat (6) @(posedge pclk);
            ext_tick <= 1'b1;
            repeat (7) @(posedge pclk);
            ext_tick <= 1'b0;
        end
    end
    // counts cycles with the transmit line low, to prove a quiet line
    always @(posedge pclk) begin
        if (txd === 1'b0) begin
            low_cnt <= low_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ctrl_val(input logic t, r, p, e, s);
        return {23'h0, s, 3'h0, p, e, s, r, t};
    endfunction : ctrl_val
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one bus transfer; an idle edge first, so psel never falls and rises in one step;
    // the wait for pready ends when pready is high; a hang is ended only by the watchdog
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, exp, rdv);
    endtask : rd
    task automatic rx_frame(input logic [7:0] v, input logic p, e, s, bp, bs);
        rem_u.send(v, p, e, s, bp, bs);
        repeat (20) @(posedge pclk);
    endtask : rx_frame
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // a hang ends the run through the same closing task
    initial begin
        repeat (90000) @(posedge pclk);
        fail_count++;
        $display("wrong value watchdog expected finish seen timeout");
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        fail_count = 0;
        tests_run = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("txd idle", 32'h1, {31'h0, txd});
        rd(st_a, 32'h0C, "status reset");
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err_seen});
        check("unmapped data", 32'h0, rdv);
        rd(rx_a, 32'h0, "rx reset");
        apb(1'b1, ct_a, ctrl_val(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        low_snap = low_cnt;
        apb(1'b1, tx_a, 32'h3C);
        repeat (300) @(posedge pclk);
        check("txd unarmed", low_snap, low_cnt);
        rd(is_a, 32'h0, "event unarmed");
        rd(st_a, 32'h0C, "status unarmed");
        $display("test reset done");
        // every framing mode, both directions
        for (int i = 0; i < 4; i++) begin
            d = 8'h35 + 8'(i * 65);
            par = i[0];
            two = i[1];
            apb(1'b1, ct_a, 32'h0);
            apb(1'b1, ct_a, ctrl_val(1'b1, 1'b1, par, two, two));
            apb(1'b1, im_a, 32'h3);
            rd(st_a, 32'h0C, "status idle");
            apb(1'b1, tx_a, {24'h0, d});
            repeat (4) @(posedge pclk);
            rd(st_a, 32'h04, "status sending");
            check("irq tx", 32'h1, {31'h0, irq});
            apb(1'b1, is_a, 32'h1);
            @(posedge pclk);
            check("irq clear", 32'h0, {31'h0, irq});
            rx_frame(~d, par, two, two, 1'b0, 1'b0);
            while (rem_u.frames <= i) @(posedge pclk);
            check("tx frame", {21'h0, par ? {2'b11, two ? ^d : ~^d} : 3'h7, d},
                {21'h0, rem_u.got});
            rd(st_a, 32'h1C, "status rx");
            check("irq rx", 32'h1, {31'h0, irq});
            rd(is_a, 32'h2, "rx event");
            apb(1'b1, is_a, 32'h2);
            rd(rx_a, {24'h0, ~d}, "rx data");
        end
        $display("test formats done");
        apb(1'b1, ct_a, 32'h0);
        apb(1'b1, ct_a, ctrl_val(1'b1, 1'b1, 1'b1, 1'b1, 1'b0));
        apb(1'b1, im_a, 32'h1);
        rx_frame(8'h5A, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        check("irq masked", 32'h0, {31'h0, irq});
        rd(st_a, 32'h9C, "parity fault");
        rd(rx_a, 32'h5A, "rx parity");
        rd(st_a, 32'h0C, "parity clear");
        rx_frame(8'h66, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        rd(st_a, 32'h5C, "framing");
        rd(rx_a, 32'h66, "rx framing");
        rd(st_a, 32'h0C, "framing clear");
        rx_frame(8'h11, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rx_frame(8'h22, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rd(st_a, 32'h3C, "overrun");
        apb(1'b1, is_a, 32'h2);
        rx_frame(8'h33, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rd(is_a, 32'h0, "rx while overrun");
        rd(rx_a, 32'h11, "rx kept");
        rd(st_a, 32'h0C, "overrun clear");
        rx_frame(8'h44, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rd(st_a, 32'h1C, "full");
        rx_frame(8'h55, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rd(rx_a, 32'h44, "rx late");
        rd(st_a, 32'h2C, "overrun kept");
        rd(rx_a, 32'h44, "rx again");
        rd(st_a, 32'h0C, "overrun gone");
        $display("test errors done");
        apb(1'b1, im_a, 32'h2);
        fork
            rx_frame(8'h77, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
            begin
                repeat (600) @(posedge pclk);
                apb(1'b1, ct_a, ctrl_val(1'b1, 1'b0, 1'b1, 1'b1, 1'b0));
            end
        join
        check("irq unmasked", 32'h1, {31'h0, irq});
        rd(st_a, 32'h1C, "after disable");
        rd(rx_a, 32'h77, "rx finished");
        rx_frame(8'h78, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rd(st_a, 32'h0C, "rx off");
        $display("test disable done");
        // baud from the external tick input, both directions
        apb(1'b1, ct_a, 32'h0);
        apb(1'b1, ct_a, ctrl_val(1'b1, 1'b1, 1'b0, 1'b0, 1'b0) | 32'hC0);
        rd(st_a, 32'h0C, "status ext");
        apb(1'b1, tx_a, 32'hA5);
        rx_frame(8'h3C, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        while (rem_u.frames < 5) @(posedge pclk);
        check("tx ext", 32'h7A5, {21'h0, rem_u.got});
        rd(st_a, 32'h1C, "status ext rx");
        rd(rx_a, 32'h3C, "rx ext");
        $display("test external tick done");
        test_done();
    end
endmodule : uart_tx_rx_status_tb
